// ===== include/aimf_pkg.sv
// package: addresses, fields, reset values and types of the converter control
package aimf_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] AIMF_ADDR_INCTL  = 8'hA5;
    localparam logic [7:0] AIMF_ADDR_CFG    = 8'hA6;
    localparam logic [7:0] AIMF_ADDR_RES_LO = 8'hAC;
    localparam logic [7:0] AIMF_ADDR_RES_HI = 8'hAD;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] AIMF_RST_INCTL = 8'h00;
    localparam logic [7:0] AIMF_RST_CFG   = 8'h00;
    localparam logic [7:0] AIMF_RST_RES   = 8'h00;

    // ------------------------------------------------------------------
    // input control fields
    // ------------------------------------------------------------------
    localparam int AIMF_BIT_CONNECT = 7;
    localparam int AIMF_BIT_INTERNAL_REFERENCE_SELECT    = 6;
    localparam int AIMF_BIT_TRG_HI  = 5;
    localparam int AIMF_BIT_TRG_LO  = 4;
    localparam int AIMF_BIT_DIFFERENTIAL_SELECT    = 3;
    localparam int AIMF_BIT_CHS_HI  = 2;

    // ------------------------------------------------------------------
    // config / status fields
    // ------------------------------------------------------------------
    localparam int AIMF_BIT_LEFT_ADJUST  = 0;
    localparam int AIMF_BIT_GO    = 1;
    localparam int AIMF_BIT_REJ   = 6;
    localparam int AIMF_BIT_BUSY  = 7;

    // ------------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------------
    localparam int AIMF_RES_W = 10;

    localparam logic [3:0] AIMF_PIN_TEMP = 4'h7;
    localparam logic [3:0] AIMF_PIN_NONE = 4'hF;
    localparam logic [2:0] AIMF_CH_TEMP  = 3'h6;
    localparam logic [2:0] AIMF_CH_LAST  = 3'h7;
    localparam logic [2:0] AIMF_PIN_LAST = 3'h6;

    typedef enum logic [1:0] {
        AIMF_TRG_SW = 2'h0,
        AIMF_TRG_T0 = 2'h1,
        AIMF_TRG_T1 = 2'h2,
        AIMF_TRG_T2 = 2'h3
    } aimf_trig_t;

    typedef enum logic [1:0] {
        AIMF_NEG_HALF = 2'h0,
        AIMF_NEG_REF  = 2'h1,
        AIMF_NEG_PIN  = 2'h2,
        AIMF_NEG_NONE = 2'h3
    } aimf_neg_t;

    typedef enum logic [2:0] {
        AIMF_ST_IDLE  = 3'h1,
        AIMF_ST_START = 3'h2,
        AIMF_ST_BUSY  = 3'h4
    } aimf_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       connect;
        logic       reserved;
        logic [3:0] pos_pin;
        aimf_neg_t  neg_kind;
        logic [3:0] neg_pin;
        logic       temp_sensor;
        logic       int_ref;
    } aimf_mux_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } aimf_res_t;

endpackage

// ===== rtl/aimf_fmt.sv
// result placement into the two 8-bit result registers
`timescale 1ns/1ps
`default_nettype none

module aimf_fmt
(
    // control
    input  wire logic                           left_adjust_i,
    // raw converter word
    input  wire logic [aimf_pkg::AIMF_RES_W-1:0] raw_i,
    // placed result
    output aimf_pkg::aimf_res_t                  res_o
);
    import aimf_pkg::*;

    always_comb
    begin
        if (left_adjust_i)
        begin
            res_o.high = raw_i[9:2];
            res_o.low  = {raw_i[1:0], 6'h00};
        end
        else
        begin
            res_o.low  = raw_i[7:0];
            // sign fill from bit 1 of the high byte
            res_o.high = {{6{raw_i[9]}}, raw_i[9:8]};
        end
    end

endmodule

`default_nettype wire

// ===== rtl/aimf_top.sv
// converter control: trigger, input multiplexer code map and result registers
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module aimf_top
(
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            nrst_i,
    // register port
    input  wire logic [7:0]                      addr_i,
    input  wire logic [7:0]                      wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic [7:0]                           rdata_o,
    // timer overflow pulses
    input  wire logic                            t0_ovf_i,
    input  wire logic                            t1_ovf_i,
    input  wire logic                            t2_ovf_i,
    // converter core
    input  wire logic                            conv_done_i,
    input  wire logic [aimf_pkg::AIMF_RES_W-1:0] conv_data_i,
    output logic                                 conv_start_o,
    output logic                                 conv_differential_select_o,
    output aimf_pkg::aimf_mux_t                  mux_o,
    // status
    output logic                                 busy_o
);
    import aimf_pkg::*;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0]  inctl_reg;
    logic        left_adjust_reg;
    logic        go_reg;
    logic        reject_reg;
    logic [7:0]  result_low_reg;
    logic [7:0]  result_high_reg;
    aimf_state_t state_reg;
    aimf_state_t state_next;
    aimf_mux_t   mux_next;
    aimf_res_t   placed;
    logic        trig_hit;
    logic        start_ok;
    logic        wr_inctl;
    logic        wr_cfg;
    aimf_trig_t  trigger_select;
    logic [2:0]  channel_select;
    logic        differential_select;
    logic        internal_reference_select;
    logic        analog_connect;

    assign trigger_select =
        aimf_trig_t'(inctl_reg[AIMF_BIT_TRG_HI:AIMF_BIT_TRG_LO]);
    assign channel_select            = inctl_reg[AIMF_BIT_CHS_HI:0];
    assign differential_select       = inctl_reg[AIMF_BIT_DIFFERENTIAL_SELECT];
    assign internal_reference_select = inctl_reg[AIMF_BIT_INTERNAL_REFERENCE_SELECT];
    assign analog_connect            = inctl_reg[AIMF_BIT_CONNECT];

    assign wr_inctl = wr_i && (addr_i == AIMF_ADDR_INCTL);
    assign wr_cfg   = wr_i && (addr_i == AIMF_ADDR_CFG);

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // result addresses are read-only: writes there are dropped
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            inctl_reg <= AIMF_RST_INCTL;
        end
        else if (wr_inctl)
        begin
            inctl_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            left_adjust_reg <= AIMF_RST_CFG[AIMF_BIT_LEFT_ADJUST];
        end
        else if (wr_cfg)
        begin
            left_adjust_reg <= wdata_i[AIMF_BIT_LEFT_ADJUST];
        end
    end

    // go request is a one-cycle pulse, consumed by the sequencer
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            go_reg <= AIMF_RST_CFG[AIMF_BIT_GO];
        end
        else
        begin
            go_reg <= wr_cfg && wdata_i[AIMF_BIT_GO];
        end
    end

    // ------------------------------------------------------------------
    // input multiplexer code map
    // ------------------------------------------------------------------
    always_comb
    begin
        mux_next             = '0;
        mux_next.int_ref     = internal_reference_select;
        mux_next.pos_pin     = AIMF_PIN_NONE;
        mux_next.neg_pin     = AIMF_PIN_NONE;
        mux_next.neg_kind    = AIMF_NEG_NONE;
        mux_next.temp_sensor = 1'b0;
        mux_next.reserved    = 1'b0;
        if (!differential_select)
        begin
            mux_next.neg_kind = AIMF_NEG_HALF;
            if (channel_select == AIMF_CH_TEMP)
            begin
                mux_next.pos_pin     = AIMF_PIN_TEMP;
                mux_next.neg_kind    = AIMF_NEG_REF;
                mux_next.temp_sensor = internal_reference_select;
            end
            else if (channel_select == AIMF_CH_LAST)
            begin
                mux_next.pos_pin = {1'b0, AIMF_PIN_LAST};
            end
            else
            begin
                mux_next.pos_pin = {1'b0, channel_select};
            end
        end
        else if (channel_select[2] || (channel_select[1:0] == 2'h3))
        begin
            // reserved pairs leave both inputs open
            mux_next.reserved = 1'b1;
        end
        else
        begin
            mux_next.neg_kind = AIMF_NEG_PIN;
            mux_next.pos_pin  = {1'b0, channel_select[1:0], 1'b0};
            mux_next.neg_pin  = {1'b0, channel_select[1:0], 1'b1};
        end
        // inputs reach the converter only while connected
        mux_next.connect = analog_connect && !mux_next.reserved;
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            mux_o       <= '0;
            conv_differential_select_o <= 1'b0;
        end
        else
        begin
            mux_o       <= mux_next;
            conv_differential_select_o <= differential_select;
        end
    end

    // ------------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------------
    always_comb
    begin
        case (trigger_select)
            AIMF_TRG_T0: trig_hit = t0_ovf_i;
            AIMF_TRG_T1: trig_hit = t1_ovf_i;
            AIMF_TRG_T2: trig_hit = t2_ovf_i;
            default:     trig_hit = go_reg;
        endcase
    end

    // a trigger on an open or reserved input would convert garbage
    assign start_ok = trig_hit && mux_o.connect;

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            AIMF_ST_IDLE:
            begin
                if (start_ok)
                begin
                    state_next = AIMF_ST_START;
                end
            end
            AIMF_ST_START:
            begin
                state_next = AIMF_ST_BUSY;
            end
            AIMF_ST_BUSY:
            begin
                if (conv_done_i)
                begin
                    state_next = AIMF_ST_IDLE;
                end
            end
            default:
            begin
                state_next = AIMF_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= AIMF_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            conv_start_o <= 1'b0;
            busy_o       <= 1'b0;
        end
        else
        begin
            conv_start_o <= (state_next == AIMF_ST_START);
            busy_o       <= (state_next != AIMF_ST_IDLE);
        end
    end

    // sticky: a trigger that found the inputs unusable or a busy core;
    // a new one in the clearing cycle wins over the clear
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            reject_reg <= 1'b0;
        end
        else if (trig_hit && !(start_ok && state_reg == AIMF_ST_IDLE))
        begin
            reject_reg <= 1'b1;
        end
        else if (wr_cfg && wdata_i[AIMF_BIT_REJ])
        begin
            reject_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------------
    aimf_fmt u_fmt
    (
        .left_adjust_i (left_adjust_reg),
        .raw_i         (conv_data_i),
        .res_o         (placed)
    );

    // placement is fixed at capture; changing adjust later needs a rerun
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            result_low_reg  <= AIMF_RST_RES;
            result_high_reg <= AIMF_RST_RES;
        end
        else if (conv_done_i && state_reg == AIMF_ST_BUSY)
        begin
            result_low_reg  <= placed.low;
            result_high_reg <= placed.high;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // reads only look; no register changes on a read
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            case (addr_i)
                AIMF_ADDR_INCTL:  rdata_o <= inctl_reg;
                AIMF_ADDR_CFG:    rdata_o <= {busy_o, reject_reg,
                                              5'h00, left_adjust_reg};
                AIMF_ADDR_RES_LO: rdata_o <= result_low_reg;
                AIMF_ADDR_RES_HI: rdata_o <= result_high_reg;
                default:          rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// ===== bench/aimf_props.sv
// checker: trigger, channel map and result placement at the top ports
`timescale 1ns/1ps
`default_nettype none

module aimf_props
(
    // clock and reset
    input wire logic                             clk_i,
    input wire logic                             nrst_i,
    // register port
    input wire logic [7:0]                       addr_i,
    input wire logic [7:0]                       wdata_i,
    input wire logic                             wr_i,
    input wire logic                             rd_i,
    input wire logic [7:0]                       rdata_o,
    // timers and converter
    input wire logic                             t0_ovf_i,
    input wire logic                             t1_ovf_i,
    input wire logic                             t2_ovf_i,
    input wire logic                             conv_done_i,
    input wire logic [aimf_pkg::AIMF_RES_W-1:0]  conv_data_i,
    input wire logic                             conv_start_o,
    input wire logic                             conv_differential_select_o,
    input wire aimf_pkg::aimf_mux_t              mux_o,
    input wire logic                             busy_o
);
    import aimf_pkg::*;

    // ------------------------------
    // shadow of writes and captures
    // ------------------------------
    logic [7:0]            inctl_q;
    logic                  left_adjust_q;
    logic                  left_adjust_w;
    logic [AIMF_RES_W-1:0] cap_q;
    logic                  wr_in;
    logic                  sel;

    assign wr_in = wr_i && addr_i == AIMF_ADDR_INCTL;
    assign sel = (inctl_q[5:4] == 2'h1 && t0_ovf_i)
        || (inctl_q[5:4] == 2'h2 && t1_ovf_i)
        || (inctl_q[5:4] == 2'h3 && t2_ovf_i);

    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            inctl_q <= AIMF_RST_INCTL;
        else if (wr_in)
            inctl_q <= wdata_i;

    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            left_adjust_w <= 1'b0;
        else if (wr_i && addr_i == AIMF_ADDR_CFG)
            left_adjust_w <= wdata_i[AIMF_BIT_LEFT_ADJUST];

    // placement frozen at capture, so adjust is captured with the word
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            cap_q  <= '0;
            left_adjust_q <= 1'b0;
        end
        else if (conv_done_i && busy_o)
        begin
            cap_q  <= conv_data_i;
            left_adjust_q <= left_adjust_w;
        end

    function automatic logic mux_ok(logic [7:0] v, aimf_mux_t m);
        logic r;
        r = v[3] && v[2:0] > 3'h2;
        return m.reserved == r && m.connect == (v[7] && !r)
            && m.neg_kind == (r ? AIMF_NEG_NONE : v[3] ? AIMF_NEG_PIN
            : v[2:0] == AIMF_CH_TEMP ? AIMF_NEG_REF : AIMF_NEG_HALF)
            && (!v[3] || r || m.neg_pin == {v[2:0], 1'b1})
            && m.int_ref == v[6]
            && m.temp_sensor == (!v[3] && v[2:0] == AIMF_CH_TEMP && v[6]);
    endfunction

    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_inctl_settled;
        wr_in ##1 !wr_in ##1 !wr_in;
    endsequence

    sequence s_conv_end;
        conv_done_i && busy_o;
    endsequence

    chk_trig_start:
    assert property (sel && mux_o.connect && !busy_o |=> conv_start_o)
        else $error("selected overflow gave no start");
    chk_start_cause:
    assert property (conv_start_o |-> $past(sel)
        || $past(wr_i && addr_i == AIMF_ADDR_CFG && wdata_i[AIMF_BIT_GO], 2))
        else $error("start without a selected trigger");
    chk_start_pulse:
    assert property (conv_start_o |=> !conv_start_o && busy_o)
        else $error("start pulse not one cycle");
    chk_busy_end:
    assert property (s_conv_end |=> !busy_o)
        else $error("busy held after done");
    chk_res_low:
    assert property (rd_i && addr_i == AIMF_ADDR_RES_LO |=> rdata_o
        == (left_adjust_q ? {cap_q[1:0], 6'h00} : cap_q[7:0]))
        else $error("low result misplaced");
    chk_res_high:
    assert property (rd_i && addr_i == AIMF_ADDR_RES_HI |=> rdata_o
        == (left_adjust_q ? cap_q[9:2] : {{6{cap_q[9]}}, cap_q[9:8]}))
        else $error("high result misplaced");
    chk_rd_quiet:
    assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_mux_map:
    assert property (s_inctl_settled |-> mux_ok(inctl_q, mux_o)
        && conv_differential_select_o == inctl_q[AIMF_BIT_DIFFERENTIAL_SELECT])
        else $error("multiplexer map wrong");
endmodule

`default_nettype wire

// ===== bench/tb.sv
// testbench: register port, triggers, channel map and result placement
`timescale 1ns/1ps
`default_nettype none

module tb;
    import aimf_pkg::*;

    // ------------------------------
    // signals
    // ------------------------------
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [2:0] tmr_ovf = 3'h0;
    logic       conv_done_i = 1'b0;
    logic [9:0] conv_data_i = 10'h000;
    logic [7:0] rdata_o;
    logic [7:0] n;
    logic [7:0] v;
    logic       conv_start_o;
    logic       conv_differential_select_o;
    logic       busy_o;
    aimf_mux_t  mux_o;
    logic [9:0] dtab [4] = '{10'h2A5, 10'h3C6, 10'h15A, 10'h2A5};
    int         errors = 0;
    int         checks = 0;
    int         starts = 0;

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i)
        if (conv_start_o === 1'b1)
            starts <= starts + 1;

    aimf_top i_aimf_top
    (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .t0_ovf_i(tmr_ovf[0]), .t1_ovf_i(tmr_ovf[1]), .t2_ovf_i(tmr_ovf[2]),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .conv_start_o(conv_start_o), .conv_differential_select_o(conv_differential_select_o),
        .mux_o(mux_o), .busy_o(busy_o)
    );

    // ------------------------------
    // tasks
    // ------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask

    // timer k, or a software start for k == 3; counts starts seen
    task automatic fire(input int k, input logic l, output logic [7:0] c);
        int s0;
        s0 = starts;
        if (k == 3)
            wr(AIMF_ADDR_CFG, {6'h00, 1'b1, l});
        else
        begin
            @(posedge clk_i);
            tmr_ovf[k] <= 1'b1;
            @(posedge clk_i);
            tmr_ovf <= 3'h0;
        end
        repeat (3) @(posedge clk_i);
        #1 c = 8'(starts - s0);
    endtask

    task automatic finish(input logic [9:0] d);
        @(posedge clk_i);
        conv_done_i <= 1'b1;
        conv_data_i <= d;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        conv_data_i <= ~d;
        @(posedge clk_i);
    endtask

    task automatic conv(input int k, input logic l, input logic [9:0] d);
        logic [7:0] c;
        wr(AIMF_ADDR_CFG, {7'h00, l});
        fire(k, l, c);
        chk(c, 8'h01);
        finish(d);
        rdchk(AIMF_ADDR_RES_LO, l ? {d[1:0], 6'h00} : d[7:0]);
        rdchk(AIMF_ADDR_RES_HI, l ? d[9:2] : {{6{d[9]}}, d[9:8]});
    endtask

    function automatic logic [3:0] pos_of(input logic [3:0] dc);
        if (dc[3])
            return (dc[2:0] < 3'h3) ? {dc[2:0], 1'b0} : AIMF_PIN_NONE;
        if (dc[2:0] == AIMF_CH_TEMP)
            return AIMF_PIN_TEMP;
        return (dc[2:0] == 3'h7) ? 4'h6 : {1'b0, dc[2:0]};
    endfunction

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------
    // tests
    // ------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdchk(AIMF_ADDR_RES_LO, AIMF_RST_RES);
        rdchk(AIMF_ADDR_RES_HI, AIMF_RST_RES);
        rdchk(8'h00, 8'h00);
        $display("reset test done");
        // connect dropped before every channel change
        for (int i = 0; i < 32; i++)
        begin
            v = {1'b0, i[4], 2'h0, i[3:0]};
            wr(AIMF_ADDR_INCTL, v);
            wr(AIMF_ADDR_INCTL, v | 8'h80);
            repeat (2) @(posedge clk_i);
            #1 chk({4'h0, mux_o.pos_pin}, {4'h0, pos_of(v[3:0])});
            chk({7'h00, conv_differential_select_o}, {7'h00, v[3]});
            if (v[3:0] == 4'h6)
                chk({7'h00, mux_o.temp_sensor}, {7'h00, v[6]});
            wr(AIMF_ADDR_INCTL, v);
        end
        $display("channel map test done");
        for (int t = 1; t < 4; t++)
        begin
            wr(AIMF_ADDR_INCTL, 8'(t << 4));
            wr(AIMF_ADDR_INCTL, 8'h80 | 8'(t << 4));
            for (int k = 0; k < 3; k++)
                if (k != t - 1)
                begin
                    fire(k, 1'b0, n);
                    chk(n, 8'h00);
                end
            conv(t - 1, t[0], dtab[t]);
        end
        wr(AIMF_ADDR_INCTL, 8'h00);
        wr(AIMF_ADDR_INCTL, 8'h80);
        conv(3, 1'b0, dtab[0]);
        wr(AIMF_ADDR_RES_LO, 8'hFF);
        rdchk(AIMF_ADDR_RES_LO, dtab[0][7:0]);
        $display("trigger and placement test done");
        // second start while busy is refused and flagged
        fire(3, 1'b0, n);
        chk(n, 8'h01);
        fire(3, 1'b0, n);
        chk(n, 8'h00);
        rdchk(AIMF_ADDR_CFG, 8'hC0);
        finish(10'h000);
        wr(AIMF_ADDR_CFG, 8'h40);
        rdchk(AIMF_ADDR_CFG, 8'h00);
        wr(AIMF_ADDR_INCTL, 8'h10);
        fire(0, 1'b0, n);
        chk(n, 8'h00);
        rdchk(AIMF_ADDR_CFG, 8'h40);
        wr(AIMF_ADDR_INCTL, 8'h1B);
        wr(AIMF_ADDR_INCTL, 8'h9B);
        fire(0, 1'b0, n);
        chk(n, 8'h00);
        $display("refusal test done");
        end_of_test();
    end

    initial
    begin
        #(25 * 20000);
        errors++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule

bind aimf_top aimf_props i_aimf_props
(
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .t0_ovf_i(t0_ovf_i),
    .t1_ovf_i(t1_ovf_i), .t2_ovf_i(t2_ovf_i), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .conv_start_o(conv_start_o),
    .conv_differential_select_o(conv_differential_select_o), .mux_o(mux_o), .busy_o(busy_o)
);

`default_nettype wire
